// ===== hdl/sccz_clkdiv.sv
// CPU clock enable divider driven by the selected ratio code
`include "sccz_defs.svh"

module sccz_clkdiv (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] ratio,
    output logic            tick
);

    sccz_pkg::sccz_div_state_t s;
    sccz_pkg::sccz_div_state_t next_s;

    function automatic logic [3:0] ratio_limit(input logic [2:0] code);
        unique case (code)
            `SCCZ_RATIO_ONE:     ratio_limit = 4'h0;
            `SCCZ_RATIO_TWO:     ratio_limit = 4'h1;
            `SCCZ_RATIO_FOUR:    ratio_limit = 4'h3;
            `SCCZ_RATIO_EIGHT:   ratio_limit = 4'h7;
            `SCCZ_RATIO_SIXTEEN: ratio_limit = 4'hF;
            default:             ratio_limit = 4'h7;
        endcase
    endfunction

    // ============================================================
    // Counter
    always_comb begin
        next_s = s;
        if (s.cnt >= ratio_limit(ratio)) begin
            next_s.cnt  = 4'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt  = s.cnt + 4'h1;
            next_s.tick = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

    // ============================================================
    // Checks
    a_div_eight_spacing: assert property (@(posedge clk) disable iff (rst)
        (tick && ratio == `SCCZ_RATIO_EIGHT && $stable(ratio)) |-> ##1 (!tick [*7]) ##1 tick
            or ##[1:8] (ratio != `SCCZ_RATIO_EIGHT))
        else $error("divide by eight tick spacing wrong");

endmodule

// ===== hdl/sccz_defs.svh
// Offsets, field positions, reset values and rule overview of the clock control block
// Overview of operation
// - Gate bit stops peripheral clock in wait
// - Bit 5: zero runs, one stops main
// - Bit 6 forces divide by eight
// - Stop entry from fast modes sets bit 6
// - Main stopped, pin bit clear: pins are inputs
// - Crystal pins usable as ports when unused
// - Reset: low-speed on-chip clock, divided by eight
// - Fast oscillator stopped until enable bit set
// - Division bits choose one, two, four, sixteen
`ifndef SCCZ_DEFS_SVH
`define SCCZ_DEFS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define SCCZ_IDX_PROTECT     6'h00
`define SCCZ_IDX_STOP_DETECT 6'h01
`define SCCZ_IDX_FAST_OSC    6'h02
`define SCCZ_IDX_STATUS      6'h03
`define SCCZ_IDX_CTL_ZERO    6'h06
`define SCCZ_IDX_CTL_ONE     6'h07

// ============================================================
// Reset values
`define SCCZ_RST_CTL_ZERO    8'h68
`define SCCZ_RST_CTL_ONE     8'h20
`define SCCZ_RST_PROTECT     8'h00
`define SCCZ_RST_STOP_DETECT 8'h04
`define SCCZ_RST_FAST_OSC    8'h00

// ============================================================
// Field positions
`define SCCZ_BIT_WAIT_GATE   2
`define SCCZ_BIT_MAIN_STOP   5
`define SCCZ_BIT_DIV_EIGHT   6
`define SCCZ_BIT_XTAL_PIN    3
`define SCCZ_BIT_DIV_LOW     6
`define SCCZ_BIT_DIV_HIGH    7
`define SCCZ_BIT_WRITE_EN    0
`define SCCZ_BIT_ONCHIP_SRC  2
`define SCCZ_BIT_FAST_EN     0

// ============================================================
// Ratio codes for the CPU clock divider
`define SCCZ_RATIO_ONE       3'h0
`define SCCZ_RATIO_TWO       3'h1
`define SCCZ_RATIO_FOUR      3'h2
`define SCCZ_RATIO_EIGHT     3'h3
`define SCCZ_RATIO_SIXTEEN   3'h4

`define SCCZ_RESP_OKAY       2'h0
`define SCCZ_RESP_SLVERR     2'h2

`endif

// ===== hdl/sccz_pkg.sv
// Types shared by the clock control block
package sccz_pkg;

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } sccz_div_state_t;

    typedef struct packed {
        logic [7:0]  ctl_zero;
        logic [7:0]  ctl_one;
        logic [7:0]  protect;
        logic [7:0]  stop_detect;
        logic [7:0]  fast_osc;
        logic        aw_held;
        logic [5:0]  aw_idx;
        logic        w_held;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [2:0]  sync_six;
        logic [2:0]  sync_seven;
        logic        pin_six;
        logic        pin_seven;
        logic        periph_en;
        logic        main_run;
        logic        fast_run;
        logic        port_mode;
        logic        onchip_src;
        logic [7:0]  port_six;
        logic [2:0]  ratio;
    } sccz_state_t;

endpackage

// ===== hdl/sccz_top.sv
// Clock control register block with AXI4-Lite slave, pin sharing and CPU clock divider
`include "sccz_defs.svh"

module sccz_top (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        WAIT_MODE,
    input  wire logic        STOP_ENTRY,
    input  wire logic        SPEED_HIGH_MED,
    input  wire logic        CRYSTAL_IN_PIN,
    input  wire logic        CRYSTAL_OUT_PIN,
    output logic             PERIPH_CLK_EN,
    output logic             MAIN_OSC_RUN,
    output logic             FAST_OSC_RUN,
    output logic             CPU_CLK_ONCHIP,
    output logic             CRYSTAL_PORT_MODE,
    output logic             PORT_FOUR_BIT_SIX,
    output logic             PORT_FOUR_BIT_SEVEN,
    output logic             CPU_CLK_TICK
);

    sccz_pkg::sccz_state_t s;
    sccz_pkg::sccz_state_t next_s;

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == `SCCZ_IDX_PROTECT) || (idx == `SCCZ_IDX_STOP_DETECT) ||
                 (idx == `SCCZ_IDX_FAST_OSC) || (idx == `SCCZ_IDX_STATUS) ||
                 (idx == `SCCZ_IDX_CTL_ZERO) || (idx == `SCCZ_IDX_CTL_ONE);
    endfunction

    // ============================================================
    // Register write and read helpers
    function automatic logic [7:0] read_byte(input sccz_pkg::sccz_state_t st, input logic [5:0] idx);
        read_byte = 8'h00;
        unique case (idx)
            `SCCZ_IDX_PROTECT:     read_byte = st.protect;
            `SCCZ_IDX_STOP_DETECT: read_byte = st.stop_detect;
            `SCCZ_IDX_FAST_OSC:    read_byte = st.fast_osc;
            `SCCZ_IDX_STATUS:      read_byte = {2'h0, st.onchip_src, st.port_mode, st.fast_run,
                                                st.main_run, st.periph_en, 1'b0};
            `SCCZ_IDX_CTL_ZERO:    read_byte = st.ctl_zero;
            `SCCZ_IDX_CTL_ONE:     read_byte = st.ctl_one;
            default:               read_byte = 8'h00;
        endcase
    endfunction

    function automatic logic [2:0] ratio_code(input logic [7:0] zero, input logic [7:0] one);
        logic [1:0] sel;
        sel = {one[`SCCZ_BIT_DIV_HIGH], one[`SCCZ_BIT_DIV_LOW]};
        if (zero[`SCCZ_BIT_DIV_EIGHT]) begin
            ratio_code = `SCCZ_RATIO_EIGHT;
        end else begin
            unique case (sel)
                2'h0: ratio_code = `SCCZ_RATIO_ONE;
                2'h1: ratio_code = `SCCZ_RATIO_TWO;
                2'h2: ratio_code = `SCCZ_RATIO_FOUR;
                2'h3: ratio_code = `SCCZ_RATIO_SIXTEEN;
            endcase
        end
    endfunction

    logic do_write;

    always_comb begin
        next_s   = s;
        do_write = s.aw_held && s.w_held && !s.bvalid;

        // ========================================================
        // Write channel capture, either order
        if (AWVALID && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx  = AWADDR[7:2];
        end
        if (WVALID && s.wready) begin
            next_s.w_held  = 1'b1;
            next_s.w_data  = WDATA[7:0];
            next_s.w_strb0 = WSTRB[0];
        end
        if (s.bvalid && BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (do_write) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = mapped(s.aw_idx) ? `SCCZ_RESP_OKAY : `SCCZ_RESP_SLVERR;
            if (s.w_strb0) begin
                unique case (s.aw_idx)
                    `SCCZ_IDX_PROTECT:     next_s.protect     = s.w_data;
                    `SCCZ_IDX_STOP_DETECT: next_s.stop_detect = s.w_data;
                    `SCCZ_IDX_FAST_OSC:    next_s.fast_osc    = s.w_data;
                    `SCCZ_IDX_CTL_ZERO: begin
                        if (s.protect[`SCCZ_BIT_WRITE_EN]) begin
                            next_s.ctl_zero = s.w_data;
                        end
                    end
                    `SCCZ_IDX_CTL_ONE: begin
                        if (s.protect[`SCCZ_BIT_WRITE_EN]) begin
                            next_s.ctl_one = s.w_data;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // stop entry from high or medium speed forces divide by eight
        if (STOP_ENTRY && SPEED_HIGH_MED) begin
            next_s.ctl_zero[`SCCZ_BIT_DIV_EIGHT] = 1'b1;
        end

        // ========================================================
        // Read channel
        if (s.rvalid && RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (ARVALID && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = {24'h00_0000, read_byte(s, ARADDR[7:2])};
            next_s.rresp  = mapped(ARADDR[7:2]) ? `SCCZ_RESP_OKAY : `SCCZ_RESP_SLVERR;
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;

        // ========================================================
        // Pin synchronisers; value moves when stages two and three agree
        next_s.sync_six   = {s.sync_six[1:0], CRYSTAL_IN_PIN};
        next_s.sync_seven = {s.sync_seven[1:0], CRYSTAL_OUT_PIN};
        if (s.sync_six[1] == s.sync_six[2]) begin
            next_s.pin_six = s.sync_six[2];
        end
        if (s.sync_seven[1] == s.sync_seven[2]) begin
            next_s.pin_seven = s.sync_seven[2];
        end

        // ========================================================
        // Clock controls
        // wait mode peripheral gating
        next_s.periph_en  = !(WAIT_MODE && next_s.ctl_zero[`SCCZ_BIT_WAIT_GATE]);
        next_s.main_run   = !next_s.ctl_zero[`SCCZ_BIT_MAIN_STOP];
        next_s.fast_run   = next_s.fast_osc[`SCCZ_BIT_FAST_EN];
        next_s.onchip_src = next_s.stop_detect[`SCCZ_BIT_ONCHIP_SRC];
        next_s.port_mode  = next_s.ctl_zero[`SCCZ_BIT_MAIN_STOP] && !next_s.ctl_one[`SCCZ_BIT_XTAL_PIN];
        // port values only in port mode
        next_s.port_six   = {6'h00, next_s.port_mode && next_s.pin_seven, next_s.port_mode && next_s.pin_six};
        next_s.ratio      = ratio_code(next_s.ctl_zero, next_s.ctl_one);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            s             <= '0;
            s.ctl_zero    <= `SCCZ_RST_CTL_ZERO;
            s.ctl_one     <= `SCCZ_RST_CTL_ONE;
            s.protect     <= `SCCZ_RST_PROTECT;
            s.stop_detect <= `SCCZ_RST_STOP_DETECT;
            s.fast_osc    <= `SCCZ_RST_FAST_OSC;
            s.awready     <= 1'b1;
            s.wready      <= 1'b1;
            s.arready     <= 1'b1;
            s.periph_en   <= 1'b1;
            s.onchip_src  <= 1'b1;
            // stop bit set, pin bit clear at reset: pins already ports
            s.port_mode   <= 1'b1;
            s.ratio       <= `SCCZ_RATIO_EIGHT;
        end else begin
            s <= next_s;
        end
    end

    sccz_clkdiv u_div (
        .clk   (MCLK),
        .rst   (RST),
        .ratio (s.ratio),
        .tick  (CPU_CLK_TICK)
    );

    assign AWREADY             = s.awready;
    assign WREADY              = s.wready;
    assign BVALID              = s.bvalid;
    assign BRESP               = s.bresp;
    assign ARREADY             = s.arready;
    assign RVALID              = s.rvalid;
    assign RDATA               = s.rdata;
    assign RRESP               = s.rresp;
    assign PERIPH_CLK_EN       = s.periph_en;
    assign MAIN_OSC_RUN        = s.main_run;
    assign FAST_OSC_RUN        = s.fast_run;
    assign CPU_CLK_ONCHIP      = s.onchip_src;
    assign CRYSTAL_PORT_MODE   = s.port_mode;
    assign PORT_FOUR_BIT_SIX   = s.port_six[0];
    assign PORT_FOUR_BIT_SEVEN = s.port_six[1];

    // ============================================================
    // Checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    sequence wr_ready_s;
        s.aw_held && s.w_held && !s.bvalid;
    endsequence

    a_write_response: assert property (wr_ready_s |=> BVALID ##0 (BRESP == $past(mapped(s.aw_idx) ? 2'h0 : 2'h2)))
        else $error("write response missing or wrong");
    a_write_protect: assert property (wr_ready_s ##0 (s.aw_idx == 6'h06 && !s.protect[0] && !STOP_ENTRY)
        |=> $stable(s.ctl_zero))
        else $error("protected register changed without enable");
    a_zero_readback: assert property ((ARVALID && ARREADY && ARADDR[7:2] == 6'h06)
        |=> RVALID && RDATA == {24'h00_0000, $past(s.ctl_zero)})
        else $error("control zero read data wrong");
    a_wait_gating: assert property (##1 (PERIPH_CLK_EN == !($past(WAIT_MODE) && s.ctl_zero[2])))
        else $error("peripheral clock gating wrong");
    a_main_stop: assert property (MAIN_OSC_RUN == !s.ctl_zero[5])
        else $error("main oscillator run disagrees with stop bit");
    a_div_force: assert property (s.ctl_zero[6] |-> s.ratio == 3'h3)
        else $error("divide by eight not forced");
    a_stop_entry: assert property ((STOP_ENTRY && SPEED_HIGH_MED) |=> s.ctl_zero[6] && s.ratio == 3'h3)
        else $error("stop entry did not select divide by eight");
    a_port_mode: assert property (CRYSTAL_PORT_MODE == (s.ctl_zero[5] && !s.ctl_one[3]))
        else $error("crystal pin port mode wrong");
    a_port_quiet: assert property (!CRYSTAL_PORT_MODE |-> !PORT_FOUR_BIT_SIX && !PORT_FOUR_BIT_SEVEN)
        else $error("port value shown while pins are crystal");
    a_fast_osc: assert property (FAST_OSC_RUN == s.fast_osc[0])
        else $error("fast oscillator run disagrees with enable");
    a_ratio_map: assert property ((!s.ctl_zero[6] && s.ctl_one[7:6] == 2'h3) |-> s.ratio == 3'h4)
        else $error("divide by sixteen not selected");
    a_onchip_src: assert property (CPU_CLK_ONCHIP == s.stop_detect[2])
        else $error("clock source flag wrong");

endmodule

// ===== tb/sccz_tb.sv
// Self-checking testbench for the clock control register block
`include "sccz_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        MCLK, RST;
    logic [7:0]  AWADDR, ARADDR;
    logic        AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP;
    logic        WAIT_MODE, STOP_ENTRY, SPEED_HIGH_MED, CRYSTAL_IN_PIN, CRYSTAL_OUT_PIN;
    logic        PERIPH_CLK_EN, MAIN_OSC_RUN, FAST_OSC_RUN, CPU_CLK_ONCHIP, CRYSTAL_PORT_MODE;
    logic        PORT_FOUR_BIT_SIX, PORT_FOUR_BIT_SEVEN, CPU_CLK_TICK;
    int          err_total, n_compared;
    logic [1:0]  last_resp;
    logic [7:0]  rd_data;

    // Byte addresses: four times the register index
    localparam logic [7:0] A_PROT = {`SCCZ_IDX_PROTECT, 2'b00};
    localparam logic [7:0] A_SDET = {`SCCZ_IDX_STOP_DETECT, 2'b00};
    localparam logic [7:0] A_FAST = {`SCCZ_IDX_FAST_OSC, 2'b00};
    localparam logic [7:0] A_STAT = {`SCCZ_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_CZ   = {`SCCZ_IDX_CTL_ZERO, 2'b00};
    localparam logic [7:0] A_CO   = {`SCCZ_IDX_CTL_ONE, 2'b00};

    sccz_top u_sccz_top (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .WAIT_MODE(WAIT_MODE), .STOP_ENTRY(STOP_ENTRY),
        .SPEED_HIGH_MED(SPEED_HIGH_MED), .CRYSTAL_IN_PIN(CRYSTAL_IN_PIN), .CRYSTAL_OUT_PIN(CRYSTAL_OUT_PIN),
        .PERIPH_CLK_EN(PERIPH_CLK_EN), .MAIN_OSC_RUN(MAIN_OSC_RUN), .FAST_OSC_RUN(FAST_OSC_RUN),
        .CPU_CLK_ONCHIP(CPU_CLK_ONCHIP), .CRYSTAL_PORT_MODE(CRYSTAL_PORT_MODE),
        .PORT_FOUR_BIT_SIX(PORT_FOUR_BIT_SIX), .PORT_FOUR_BIT_SEVEN(PORT_FOUR_BIT_SEVEN),
        .CPU_CLK_TICK(CPU_CLK_TICK));

    // ============================================================
    // Clock, closing and comparison
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic finish_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
    endtask

    // ============================================================
    // AXI4-Lite master: hold each channel until its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st = 4'hF);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        AWADDR <= a;
        WDATA <= {24'h0, d};
        WSTRB <= st;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge MCLK);
            if (AWVALID && AWREADY) begin
                aw_ok = 1'b1;
                AWVALID <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_ok = 1'b1;
                WVALID <= 1'b0;
            end
        end
        do @(posedge MCLK); while (BVALID !== 1'b1);
        last_resp = BRESP;
    endtask

    task automatic rd(input logic [7:0] a);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge MCLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge MCLK); while (RVALID !== 1'b1);
        rd_data = RDATA[7:0];
        last_resp = RRESP;
    endtask

    // Cycles between two successive divider pulses
    task automatic period(output int n);
        do @(posedge MCLK); while (CPU_CLK_TICK !== 1'b1);
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (CPU_CLK_TICK !== 1'b1 && n < 64);
    endtask

    // ============================================================
    // Scenarios
    task automatic test_reset();
        rd(A_CZ);
        check(rd_data, `SCCZ_RST_CTL_ZERO);
        rd(A_STAT);
        check(rd_data, 8'h32);
        check({MAIN_OSC_RUN, FAST_OSC_RUN, CPU_CLK_ONCHIP}, 3'b001);
        check(CRYSTAL_PORT_MODE, 1'b1);
    endtask

    task automatic test_protect();
        // Locked write must leave the register as it was
        // reserved bits kept
        wr(A_CZ, 8'h48);
        check(last_resp, `SCCZ_RESP_OKAY);
        rd(A_CZ);
        check(rd_data, 8'h68);
        wr(A_PROT, 8'h01);
        wr(A_CZ, 8'h48);
        rd(A_CZ);
        check(rd_data, 8'h48);
        cyc(2);
        check({MAIN_OSC_RUN, CRYSTAL_PORT_MODE}, 2'b10);
        wr(A_CZ, 8'h68);
        cyc(2);
        check(MAIN_OSC_RUN, 1'b0);
    endtask

    task automatic test_wait_gate();
        WAIT_MODE <= 1'b1;
        cyc(3);
        check(PERIPH_CLK_EN, 1'b1);
        wr(A_CZ, 8'h6C);
        cyc(2);
        check(PERIPH_CLK_EN, 1'b0);
        WAIT_MODE <= 1'b0;
        cyc(3);
        check(PERIPH_CLK_EN, 1'b1);
        wr(A_CZ, 8'h68);
    endtask

    task automatic test_divider();
        int n;
        int exp_n[4];
        exp_n = '{1, 2, 4, 16};
        period(n);
        check(n, 8);
        // Bit 3 set keeps the crystal pins out of port mode
        for (int i = 0; i < 4; i++) begin
            wr(A_CO, {i[1:0], 6'h28});
            wr(A_CZ, 8'h28);
            period(n);
            period(n);
            check(n, exp_n[i]);
            wr(A_CZ, 8'h68);
            period(n);
            period(n);
            check(n, 8);
        end
    endtask

    task automatic test_stop_entry();
        wr(A_CZ, 8'h28);
        STOP_ENTRY <= 1'b1;
        SPEED_HIGH_MED <= 1'b0;
        cyc(1);
        STOP_ENTRY <= 1'b0;
        rd(A_CZ);
        check(rd_data, 8'h28);
        STOP_ENTRY <= 1'b1;
        SPEED_HIGH_MED <= 1'b1;
        cyc(1);
        STOP_ENTRY <= 1'b0;
        SPEED_HIGH_MED <= 1'b0;
        rd(A_CZ);
        check(rd_data, 8'h68);
    endtask

    task automatic test_pins();
        wr(A_CO, 8'h20);
        CRYSTAL_IN_PIN <= 1'b1;
        CRYSTAL_OUT_PIN <= 1'b0;
        cyc(8);
        check({CRYSTAL_PORT_MODE, PORT_FOUR_BIT_SIX, PORT_FOUR_BIT_SEVEN}, 3'b110);
        CRYSTAL_IN_PIN <= 1'b0;
        CRYSTAL_OUT_PIN <= 1'b1;
        cyc(8);
        check({PORT_FOUR_BIT_SIX, PORT_FOUR_BIT_SEVEN}, 2'b01);
        wr(A_CO, 8'h28);
        cyc(8);
        check({CRYSTAL_PORT_MODE, PORT_FOUR_BIT_SEVEN}, 2'b00);
    endtask

    task automatic test_misc();
        wr(A_FAST, 8'h01);
        cyc(2);
        check(FAST_OSC_RUN, 1'b1);
        // Byte lane off: write must not store
        wr(A_FAST, 8'h00, 4'h0);
        cyc(2);
        check(FAST_OSC_RUN, 1'b1);
        // Detection off while main is stopped clears the on-chip source flag
        wr(A_SDET, 8'h00);
        cyc(2);
        check(CPU_CLK_ONCHIP, 1'b0);
        wr(A_SDET, 8'h04);
        wr(8'h40, 8'h55);
        check(last_resp, `SCCZ_RESP_SLVERR);
        rd(8'h40);
        check({last_resp, rd_data}, {`SCCZ_RESP_SLVERR, 8'h00});
    endtask

    // ============================================================
    // Main sequence and watchdog
    initial begin
        err_total = 0;
        n_compared = 0;
        RST = 1'b1;
        {AWADDR, ARADDR, WDATA, WSTRB} = '0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {WAIT_MODE, STOP_ENTRY, SPEED_HIGH_MED, CRYSTAL_IN_PIN, CRYSTAL_OUT_PIN} = '0;
        cyc(2);
        RST <= 1'b0;
        cyc(1);
        test_reset();
        test_protect();
        test_wait_gate();
        test_divider();
        test_stop_entry();
        test_pins();
        test_misc();
        finish_test();
    end

    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule
